// file: core/irq_state_pkg.sv
`default_nettype none
package irq_state_pkg;
  // ------------------------------------------------------------
  // Sizing
  // ------------------------------------------------------------
  localparam int NUM_IRQ = 32;        // Interrupt lines built
  localparam int IRQ_ID_W = 5;        // Bits to number a line
  localparam int PRIO_W = 8;          // Priority field width
  localparam int PRIO_BITS = 4;       // Priority bits kept
  localparam int NUM_PRIO_WORDS = NUM_IRQ / 4;
  localparam int TRIG_ID_W = 9;       // Trigger index field
  localparam int ALLOW_BIT = 4;       // Bit in system control
  // ------------------------------------------------------------
  // Byte offsets of the register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_ENA_SET = 12'h100;
  localparam logic [11:0] OFS_ENA_CLR = 12'h180;
  localparam logic [11:0] OFS_PEND_SET = 12'h200;
  localparam logic [11:0] OFS_PEND_CLR = 12'h280;
  localparam logic [11:0] OFS_ACTIVE = 12'h300;
  localparam logic [11:0] OFS_PRIO = 12'h400;
  localparam logic [11:0] OFS_SYS_CTRL = 12'hd10;
  localparam logic [11:0] OFS_TRIGGER = 12'hf00;
  // ------------------------------------------------------------
  // Reset values and masks
  // ------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] PRIO_MASK = 8'hf0;
  // ------------------------------------------------------------
  // Core handshake carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic svc_enter;             // Core enters a routine
    logic svc_return;            // Core returns from one
    logic [IRQ_ID_W-1:0] id;     // Line concerned
  } core_evt_t;
  typedef struct packed {
    logic valid;                 // A line is ready to take
    logic [IRQ_ID_W-1:0] id;     // Winning line
    logic [PRIO_W-1:0] prio;     // Its priority value
  } core_req_t;
endpackage
`default_nettype wire

// file: core/irq_state_priority_trigger.sv
// Function
// - Active flag per line, read as word
// - Eight-bit priority per line, four per word
// - Byte writes update one priority only
// - Smaller priority value is more urgent
// - Unbuilt low priority bits read zero
// - Line m at word m/4, lane m%4
// - Trigger write pends line by index
// - Unprivileged trigger only when allow bit set
// - Pulse inputs sampled on clock, latched
// - Routine entry clears pending, sets active
// - High level input while not active pends
// - Rising pulse input edge pends
// - Set-pending or trigger write pends
// - Level return resamples input for pending
// - Pulse during routine leaves it pending
// - Pulse with no new pulse returns inactive
// - Level clear ignored while input high
// - Pulse clear drops pending only
// - Disabled lines still become pending
// - Only aligned accesses are supported
// - Line count fixed at 32 by NUM_IRQ
// - Only enabled pending lines offered, by priority
// - Clear-pending leaves active untouched
`timescale 1ns/1ps
`default_nettype none
module irq_state_priority_trigger (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [2:0] pprot,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] irq_in,
  input wire logic [31:0] irq_is_pulse,
  input wire irq_state_pkg::core_evt_t core_evt,
  output irq_state_pkg::core_req_t core_req
);
  import irq_state_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [NUM_IRQ-1:0] enable;       // Enable bits
  logic [NUM_IRQ-1:0] pending;      // Pending flags
  logic [NUM_IRQ-1:0] active;       // Active flags
  logic [PRIO_W-1:0] prio [NUM_IRQ]; // Priority fields
  logic user_allow;                 // Unprivileged trigger ok
  logic [NUM_IRQ-1:0] sync_a;       // First sync stage
  logic [NUM_IRQ-1:0] sync_b;       // Second sync stage
  logic [NUM_IRQ-1:0] sync_d;       // Delayed for edges

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic sel_eset, sel_eclr, sel_pset, sel_pclr;
  logic sel_act, sel_prio, sel_ctrl, sel_trig;
  logic hit;                        // Address is mapped
  logic priv;                       // Privileged access
  logic err;                        // Access is refused
  logic wr_go;                      // Write takes effect now
  logic [2:0] prio_word;            // Priority word index
  logic [31:0] rd_mux;              // Read value

  // Low address bits are not decoded: only aligned words
  // are expected, so an odd byte address aliases its word
  always_comb begin
    sel_eset = (paddr[11:2] == OFS_ENA_SET[11:2]);
    sel_eclr = (paddr[11:2] == OFS_ENA_CLR[11:2]);
    sel_pset = (paddr[11:2] == OFS_PEND_SET[11:2]);
    sel_pclr = (paddr[11:2] == OFS_PEND_CLR[11:2]);
    sel_act = (paddr[11:2] == OFS_ACTIVE[11:2]);
    sel_ctrl = (paddr[11:2] == OFS_SYS_CTRL[11:2]);
    sel_trig = (paddr[11:2] == OFS_TRIGGER[11:2]);
    // Priority block spans NUM_PRIO_WORDS words
    sel_prio = (paddr[11:5] == OFS_PRIO[11:5]);
    prio_word = paddr[4:2];
    hit = sel_eset | sel_eclr | sel_pset | sel_pclr | sel_act
        | sel_prio | sel_ctrl | sel_trig;
  end

  // Privilege comes with the bus protection bits
  assign priv = pprot[0];

  // Trigger alone may be opened to unprivileged code
  always_comb begin
    err = ~hit;
    if (!priv && !(sel_trig && user_allow)) begin
      err = 1'b1;
    end
  end

  // Zero wait states; refusal shows on pslverr
  assign pready = 1'b1;
  assign pslverr = psel & penable & err;
  assign wr_go = psel & penable & pwrite & ~err;

  // Read multiplexer
  always_comb begin
    rd_mux = RST_WORD;
    if (sel_eset || sel_eclr) begin
      rd_mux = enable;
    end else if (sel_pset || sel_pclr) begin
      rd_mux = pending;
    end else if (sel_act) begin
      rd_mux = active;
    end else if (sel_ctrl) begin
      rd_mux[ALLOW_BIT] = user_allow;
    end else if (sel_prio) begin
      // Lane 0 in the low byte up to lane 3 on top
      rd_mux = {prio[{prio_word, 2'd3}],
                prio[{prio_word, 2'd2}],
                prio[{prio_word, 2'd1}],
                prio[{prio_word, 2'd0}]};
    end
  end

  // ------------------------------------------------------------
  // Read data register
  // ------------------------------------------------------------
  // Captured in the setup phase so the access phase can
  // answer at once from a flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prdata <= RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= err ? RST_WORD : rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Write strobes as line vectors
  // ------------------------------------------------------------
  logic [NUM_IRQ-1:0] w_eset, w_eclr, w_pset, w_pclr;
  logic [NUM_IRQ-1:0] trig_vec;     // Trigger one-hot
  logic [NUM_IRQ-1:0] enter_vec;    // Routine entry one-hot
  logic [NUM_IRQ-1:0] ret_vec;      // Routine return one-hot
  logic trig_in_range;              // Index names a built line

  // Indices 32 to 511 are dropped silently; bits above the 9-bit field are ignored
  assign trig_in_range =
    (pwdata[TRIG_ID_W-1:IRQ_ID_W] == '0);

  always_comb begin
    w_eset = (wr_go && sel_eset) ? pwdata : '0;
    w_eclr = (wr_go && sel_eclr) ? pwdata : '0;
    w_pset = (wr_go && sel_pset) ? pwdata : '0;
    w_pclr = (wr_go && sel_pclr) ? pwdata : '0;
    trig_vec = '0;
    if (wr_go && sel_trig && trig_in_range) begin
      trig_vec[pwdata[IRQ_ID_W-1:0]] = 1'b1;
    end
    enter_vec = '0;
    ret_vec = '0;
    if (core_evt.svc_enter) begin
      enter_vec[core_evt.id] = 1'b1;
    end
    if (core_evt.svc_return) begin
      ret_vec[core_evt.id] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  // Lines come from peripherals off this clock. A pulse must
  // stay high a full clock to be seen here, and a level line
  // must hold until serviced, or it may be missed.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= '0;
      sync_b <= '0;
      sync_d <= '0;
    end else begin
      sync_a <= irq_in;
      sync_b <= sync_a;
      sync_d <= sync_b;
    end
  end

  // ------------------------------------------------------------
  // Pending and active next state
  // ------------------------------------------------------------
  logic [NUM_IRQ-1:0] lvl;          // Level-type lines
  logic [NUM_IRQ-1:0] rise;         // Pulse edge seen
  logic [NUM_IRQ-1:0] hw_set;       // Hardware pend events
  logic [NUM_IRQ-1:0] sw_set;       // Software pend events
  logic [NUM_IRQ-1:0] clr;          // Pend removals
  logic [NUM_IRQ-1:0] next_pending;
  logic [NUM_IRQ-1:0] next_active;

  assign lvl = ~irq_is_pulse;
  assign rise = irq_is_pulse & sync_b & ~sync_d;

  always_comb begin
    // Level line pends while high and idle, and is
    // resampled on return; entry itself must not re-pend
    hw_set = (lvl & sync_b & ((~active & ~enter_vec)
             | ret_vec))
           | rise;
    sw_set = w_pset | trig_vec;
    // A level clear holds while its input is still high
    clr = enter_vec
        | (w_pclr & irq_is_pulse)
        | (w_pclr & lvl & ~sync_b);
    // Set beats clear, so a same-cycle event is kept;
    // enable is not consulted here at all
    next_pending = hw_set | sw_set | (pending & ~clr);
    // Clear-pending never touches the active flag
    next_active = enter_vec | (active & ~ret_vec);
  end

  // Pending flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pending <= '0;
    end else begin
      pending <= next_pending;
    end
  end

  // Active flags; a pulse line with no new pulse ends
  // inactive on return, one with a pulse ends pending
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active <= '0;
    end else begin
      active <= next_active;
    end
  end

  // Enable bits: set and clear by separate words
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      enable <= '0;
    end else begin
      enable <= (enable | w_eset) & ~w_eclr;
    end
  end

  // System control allow bit, privileged writes only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      user_allow <= 1'b0;
    end else if (wr_go && sel_ctrl) begin
      user_allow <= pwdata[ALLOW_BIT];
    end
  end

  // ------------------------------------------------------------
  // Priority fields
  // ------------------------------------------------------------
  // Each lane has its own strobe; unbuilt low bits are
  // masked on the way in so they always read as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        prio[i] <= RST_PRIO;
      end
    end else if (wr_go && sel_prio) begin
      for (int l = 0; l < 4; l++) begin
        if (pstrb[l]) begin
          prio[{prio_word, 2'(l)}] <=
            pwdata[8*l +: 8] & PRIO_MASK;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Arbiter
  // ------------------------------------------------------------
  logic [NUM_IRQ-1:0] cand;         // Lines that may be taken
  logic found;                      // Any candidate
  logic [IRQ_ID_W-1:0] best_id;     // Winning line
  logic [PRIO_W-1:0] best_prio;     // Winning value

  // A line already in its routine is not offered again
  assign cand = pending & enable & ~active;

  // Scan from the top with a non-strict compare so the
  // lowest number wins a tie; costs a long compare chain
  always_comb begin
    found = 1'b0;
    best_id = '0;
    best_prio = '1;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (cand[i] && (prio[i] <= best_prio)) begin
        found = 1'b1;
        best_id = IRQ_ID_W'(i);
        best_prio = prio[i];
      end
    end
  end

  // Request to the core, held in flops
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_req <= '0;
    end else begin
      core_req.valid <= found;
      core_req.id <= best_id;
      core_req.prio <= best_prio;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [IRQ_ID_W-1:0] id_q;        // Event line, delayed
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      id_q <= '0;
    end else begin
      id_q <= core_evt.id;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ENTER_ACTIVE: assert property (
    core_evt.svc_enter && !core_evt.svc_return
    && lvl[core_evt.id] && !sw_set[core_evt.id]
    |=> active[id_q] && !pending[id_q])
    else $error("entry did not make line active only");

  AST_RETURN_IDLE: assert property (
    core_evt.svc_return && !core_evt.svc_enter
    && irq_is_pulse[core_evt.id] && !rise[core_evt.id]
    && !sw_set[core_evt.id] && !pending[core_evt.id]
    |=> !active[id_q] && !pending[id_q])
    else $error("pulse line not inactive after return");

  // Line 3 is the pulse line and line 8 the level line
  // that the bench walks through every state
  AST_PULSE_LATCH: assert property (
    irq_is_pulse[3] && $rose(irq_in[3])
    && !core_evt.svc_enter && !w_pclr[3]
    |-> ##[1:3] pending[3])
    else $error("pulse on line 3 not latched");

  AST_EDGE_PENDS: assert property (
    rise[3] |=> pending[3])
    else $error("edge on line 3 did not pend");

  AST_LEVEL_PENDS: assert property (
    lvl[8] && sync_b[8] && !active[8] && !enter_vec[8]
    |=> pending[8])
    else $error("high idle level line 8 not pending");

  AST_LEVEL_RETURN: assert property (
    lvl[8] && sync_b[8] && ret_vec[8] && !enter_vec[8]
    |=> pending[8] && !active[8])
    else $error("level line 8 not re-pended on return");

  AST_LEVEL_CLR_HELD: assert property (
    lvl[8] && sync_b[8] && pending[8] && w_pclr[8]
    && !enter_vec[8] |=> pending[8])
    else $error("level clear took effect while high");

  AST_PULSE_CLR: assert property (
    irq_is_pulse[3] && w_pclr[3] && !rise[3]
    && !sw_set[3] && active[3] && !ret_vec[3]
    |=> !pending[3] && active[3])
    else $error("pulse clear wrong on line 3");

  AST_USER_REFUSED: assert property (
    psel && penable && sel_trig && !priv && !user_allow
    |-> pslverr && trig_vec == '0)
    else $error("unprivileged trigger not refused");

  AST_LOW_BITS_ZERO: assert property (
    (prio[0] & ~PRIO_MASK) == '0)
    else $error("unbuilt priority bits not zero");

  AST_NO_CAND_NO_REQ: assert property (
    cand == '0 |=> !core_req.valid)
    else $error("request raised with no candidate");

  AST_TRIG_PENDS: assert property (
    trig_vec[5] |=> pending[5])
    else $error("trigger write did not pend line 5");

  COV_NESTED: cover property (
    active[3] && rise[3] ##1 active[3] && pending[3]);
  COV_USER_TRIG: cover property (
    wr_go && sel_trig && !priv);
  COV_TIE: cover property (
    cand[13] && cand[14] && prio[13] == prio[14]);
  COV_BYTE_PRIO: cover property (
    wr_go && sel_prio && pstrb == 4'h4);

endmodule // irq_state_priority_trigger
`default_nettype wire

// file: verif/irq_far_side.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Peripheral request lines and processor core events
// ------------------------------------------------------------
module irq_far_side (
  input wire logic clk_sys,
  output logic [31:0] irq_in,
  output irq_state_pkg::core_evt_t core_evt
);
  import irq_state_pkg::*;

  // Quiet lines and no event at time zero
  initial begin
    irq_in = '0;
    core_evt = '0;
  end

  // One full clock high, so the sampler cannot miss it
  task automatic pulse(input int n);
    @(posedge clk_sys);
    irq_in[n] <= 1'b1;
    @(posedge clk_sys);
    irq_in[n] <= 1'b0;
  endtask

  // Level held until the routine has dealt with its cause
  task automatic level(input int n, input logic v);
    @(posedge clk_sys);
    irq_in[n] <= v;
  endtask

  // Entry or return pulse, optionally after a slow start
  task automatic evt(input logic ent, input logic [IRQ_ID_W-1:0] id,
    input int dly);
    repeat (dly) @(posedge clk_sys);
    @(posedge clk_sys);
    core_evt <= '{ent, !ent, id};
    @(posedge clk_sys);
    // Id scrambled between events so nothing leans on a stale one
    core_evt <= '{1'b0, 1'b0, ~id};
  endtask
endmodule // irq_far_side
`default_nettype wire

// file: verif/tb_irq_state_priority_trigger.sv
`timescale 1ns/1ps
`default_nettype none
module tb_irq_state_priority_trigger;
  import irq_state_pkg::*;
  // ------------------------------------------------------------
  // Signals and bookkeeping
  // ------------------------------------------------------------
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, irq_in, irq_is_pulse;
  logic [3:0] pstrb;
  logic [2:0] pprot;
  core_evt_t core_evt;
  core_req_t core_req;
  logic [7:0] exp_prio [NUM_IRQ]; // Priorities as they should read
  int mismatches = 0;
  int n_compared = 0;

  irq_state_priority_trigger u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pprot(pprot), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_in(irq_in),
    .irq_is_pulse(irq_is_pulse), .core_evt(core_evt),
    .core_req(core_req));
  irq_far_side u_far (.clk_sys(clk_sys), .irq_in(irq_in),
    .core_evt(core_evt));

  // 25 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; a missing pready is cut short and counted
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] dw, input logic [3:0] s, input logic [2:0] p,
    input logic e, output logic [31:0] dr);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dw;
    pstrb <= s;
    pprot <= p;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    dr = prdata;
    check({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    logic [31:0] x;
    xfer(1'b1, a, d, s, 3'b001, 1'b0, x);
  endtask

  // Privileged read, compared with what is expected
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    xfer(1'b0, a, 32'h0, 4'h0, 3'b001, 1'b0, d);
    check(d, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] bit1(input int n);
    return 32'h1 << n;
  endfunction

  function automatic logic [31:0] prio_word(input int k);
    return {exp_prio[4*k+3], exp_prio[4*k+2],
            exp_prio[4*k+1], exp_prio[4*k]};
  endfunction

  // Offer expected from the core request carrier
  function automatic logic [31:0] req(input logic [4:0] id,
    input logic [7:0] p);
    return {18'h0, 1'b1, id, p};
  endfunction

  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of under 2000 cycles
  initial begin
    tick(20000);
    mismatches++;
    end_of_test();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [7:0] v;
    rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pprot = 3'b000;
    irq_is_pulse = 32'h0000_00ff; // Lines 0-7 pulse, rest level
    void'($urandom(32'he3364e4d));
    tick(16);
    rst_n <= 1'b1;
    tick(2);
    // Everything clear after reset
    for (int k = 0; k < 11; k++) begin
      rc(k < 3 ? 12'(256 * (k + 1)) : 12'(OFS_PRIO + 4 * (k - 3)),
        32'h0);
    end
    // Single-lane priority writes; full data tests the neighbours
    for (int k = 0; k < NUM_IRQ; k++) begin
      v = (k == 0) ? 8'hff : 8'($urandom);
      exp_prio[k] = v & PRIO_MASK;
      wr(OFS_PRIO + 12'(4 * (k / 4)), {4{v}}, 4'h1 << (k % 4));
    end
    for (int k = 0; k < NUM_PRIO_WORDS; k++) begin
      rc(OFS_PRIO + 12'(4 * k), prio_word(k));
    end
    // Unmapped place is refused and reads zero
    xfer(1'b0, 12'h004, 32'h0, 4'h0, 3'b001, 1'b1, d);
    check(d, 32'h0);
    // Software trigger, privileged then user with the allow bit
    wr(OFS_TRIGGER, 32'h0000_0005);
    rc(OFS_PEND_SET, bit1(5));
    xfer(1'b1, OFS_TRIGGER, 32'h6, 4'hf, 3'b000, 1'b1, d);
    rc(OFS_PEND_SET, bit1(5));
    wr(OFS_SYS_CTRL, 32'h1 << ALLOW_BIT);
    xfer(1'b1, OFS_TRIGGER, 32'h6, 4'hf, 3'b000, 1'b0, d);
    wr(OFS_TRIGGER, 32'd40);
    wr(OFS_TRIGGER, 32'hffff_fe07);
    rc(OFS_PEND_SET, 32'h0000_00e0);
    wr(OFS_PEND_CLR, 32'hffff_ffff);
    rc(OFS_PEND_SET, 32'h0);
    // Pulse line 3, first while disabled
    u_far.pulse(3);
    tick(4);
    rc(OFS_PEND_SET, bit1(3));
    check({31'h0, core_req.valid}, 32'h0);
    wr(OFS_ENA_SET, bit1(3));
    tick(2);
    check({18'h0, core_req}, req(5'd3, exp_prio[3]));
    u_far.evt(1'b1, 5'd3, 0);
    rc(OFS_ACTIVE, bit1(3));
    rc(OFS_PEND_SET, 32'h0);
    u_far.pulse(3);
    tick(4);
    rc(OFS_PEND_SET, bit1(3));
    wr(OFS_PEND_CLR, bit1(3));
    rc(OFS_PEND_SET, 32'h0);
    rc(OFS_ACTIVE, bit1(3));
    u_far.pulse(3);
    tick(4);
    u_far.evt(1'b0, 5'd3, 0);
    rc(OFS_PEND_SET, bit1(3));
    rc(OFS_ACTIVE, 32'h0);
    u_far.evt(1'b1, 5'd3, 3);
    u_far.evt(1'b0, 5'd3, 2);
    rc(OFS_PEND_SET, 32'h0);
    rc(OFS_ACTIVE, 32'h0);
    // Level line 8 through routine, return and clears
    u_far.level(8, 1'b1);
    tick(4);
    rc(OFS_PEND_SET, bit1(8));
    u_far.evt(1'b1, 5'd8, 1);
    rc(OFS_ACTIVE, bit1(8));
    u_far.evt(1'b0, 5'd8, 0);
    rc(OFS_PEND_SET, bit1(8));
    wr(OFS_PEND_CLR, bit1(8));
    rc(OFS_PEND_SET, bit1(8));
    u_far.level(8, 1'b0);
    tick(4);
    wr(OFS_PEND_CLR, bit1(8));
    rc(OFS_PEND_SET, 32'h0);
    // Arbitration: lines 12 and 15 at 0x20, 13 and 14 at 0x10
    wr(OFS_PRIO + 12'h00c, 32'h2010_1020);
    wr(OFS_ENA_SET, 32'h0000_f000);
    wr(OFS_PEND_SET, 32'h0000_d000);
    tick(2);
    check({18'h0, core_req}, req(5'd14, 8'h10));
    wr(OFS_PEND_SET, bit1(13));
    tick(2);
    check({18'h0, core_req}, req(5'd13, 8'h10));
    // Disabling the winner hands the offer to its tied neighbour
    wr(OFS_ENA_CLR, bit1(13));
    rc(OFS_ENA_CLR, 32'h0000_d008);
    check({18'h0, core_req}, req(5'd14, 8'h10));
    end_of_test();
  end
endmodule // tb_irq_state_priority_trigger
`default_nettype wire
